/* design/gptc_pkg.sv */
// Shared constants and types for the time-capture pin port.
package gptc_pkg;

   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int NUM_PINS = 12;
   localparam int NUM_TIME_PINS = 2;
   localparam int TIME_PIN_BASE = 8;
   localparam int NUM_LED_PINS = 8;
   localparam int NUM_STAMP_SRC = 6;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_DATA_DIR = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_PIN_IRQ = 8'h08;
   localparam logic [7:0] OFS_TIME_IRQ = 8'h0C;
   localparam logic [7:0] OFS_EVENT_MODE = 8'h10;
   localparam logic [7:0] OFS_SYS_STATUS = 8'h14;
   localparam logic [7:0] OFS_CAP8_LO = 8'h18;
   localparam logic [7:0] OFS_CAP8_HI = 8'h1C;
   localparam logic [7:0] OFS_CAP9_LO = 8'h20;
   localparam logic [7:0] OFS_CAP9_HI = 8'h24;
   localparam logic [7:0] OFS_LED_MODE = 8'h28;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int POS_DIR = 16;
   localparam int POS_DRV = 0;
   localparam int POS_IRQ_POL = 12;
   localparam int POS_TIME_OE = 24;
   localparam int POS_EVT_POL = 26;
   localparam int POS_TCLR_EN = 28;
   localparam int POS_IRQ_EN = 16;
   localparam int POS_CAP8_FLAG = 6;
   localparam int POS_CAP9_FLAG = 7;
   localparam int POS_TIMER_FLAG = 8;
   localparam int NUM_TIME_FLAGS = 9;
   localparam int POS_SYS_PIN_IRQ = 12;
   localparam int POS_SYS_TIME_EVT = 13;

   // ------------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------------
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int CAPTURE_MIN_NS = 40;
   localparam int PULSE_NS = 100;
   // Strictly longer than the minimum, so one cycle beyond it.
   localparam int CAPTURE_CYC = CAPTURE_MIN_NS / CLK_PERIOD_NS + 1;
   localparam int PULSE_CYC = PULSE_NS / CLK_PERIOD_NS;
   localparam int STRAP_WAIT = 3;

   typedef enum logic [1:0] {
      GPTC_EVT_PULSE  = 2'h0,
      GPTC_EVT_TOGGLE = 2'h1,
      GPTC_EVT_FOLLOW = 2'h2
   } gptc_evt_mode_t;

   typedef struct packed {
      logic [NUM_PINS-1:0] out;
      logic [NUM_PINS-1:0] oe;
   } gptc_pins_t;

endpackage

/* design/gptc_port.sv */
// Twelve-pin port with time capture, compare output and APB registers.
//
// Summary of operation
// - twelve pins, input, push-pull or open-drain.
// - reset clears all direction bits.
// - reset clears all pin interrupt enables.
// - reset clears all pin interrupt polarities.
// - driver type bit picks push-pull or open-drain.
// - open-drain drives low on 0, releases on 1.
// - output pin drives its value bit.
// - input pin value reads pin level.
// - pins 9,8 direction uses time output enable.
// - active edge captures time into pin registers.
// - capture edge sets pin and capture flags.
// - enabled edge clears target compare flag.
// - input must stay active over 40 ns.
// - pins 9,8 output compare-derived signal.
// - time flags: stamps, two captures, compare.
// - enabled time flags ORed into event bit.
// - straps may make pins 7..0 LEDs.
// - polarity bit chooses high or low level.
// - enabled pin flags ORed into bit 12.
// - time output enable forces pin to output.
// - compare output pulses, toggles or follows flag.
module gptc_port
   import gptc_pkg::*;
#(
   parameter int PULSE_CYCLES   = PULSE_CYC,
   parameter int CAPTURE_CYCLES = CAPTURE_CYC
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [NUM_PINS-1:0]      pin_in,
   output gptc_pins_t                    pins,
   input  wire logic [63:0]              time_clock,
   input  wire logic                     target_event,
   input  wire logic [NUM_STAMP_SRC-1:0] stamp_event,
   input  wire logic [NUM_LED_PINS-1:0]  led_enable_straps,
   input  wire logic [NUM_LED_PINS-1:0]  led_on,
   output logic                          pin_irq_summary,
   output logic                          time_unit_event_bit
);

   // ------------------------------------------------------------------
   // Registers and wires
   // ------------------------------------------------------------------
   logic [NUM_PINS-1:0]       pin_value_bits;
   logic [NUM_PINS-1:0]       pin_direction_bits;
   logic [NUM_PINS-1:0]       pin_driver_type_bits;
   logic [NUM_PINS-1:0]       pin_irq_polarity_bits;
   logic [NUM_TIME_PINS-1:0]  time_oe;
   logic [NUM_TIME_PINS-1:0]  event_pol;
   logic [NUM_TIME_PINS-1:0]  target_clear_en;
   logic [3:0]                event_mode;
   logic [NUM_PINS-1:0]       pin_irq_flag;
   logic [NUM_PINS-1:0]       pin_irq_en;
   logic [NUM_TIME_FLAGS-1:0] time_flag;
   logic [NUM_TIME_FLAGS-1:0] time_en;
   logic [NUM_LED_PINS-1:0]   led_mode;
   logic [NUM_PINS-1:0]       sync_a;
   logic [NUM_PINS-1:0]       pin_level;
   logic [NUM_LED_PINS-1:0]   strap_a;
   logic [NUM_LED_PINS-1:0]   strap_b;
   logic [1:0]                strap_wait;
   logic                      strap_taken;
   logic [31:0]               cap_lo [NUM_TIME_PINS];
   logic [31:0]               cap_hi [NUM_TIME_PINS];
   logic [NUM_TIME_PINS-1:0]  capture_fire;
   logic [NUM_TIME_PINS-1:0]  event_level;
   logic [NUM_PINS-1:0]       eff_dir;
   logic [NUM_PINS-1:0]       drive_value;
   logic                      wr_en;
   logic                      rd_setup;
   logic                      addr_ok;
   logic [31:0]               next_prdata;
   logic [NUM_PINS-1:0]       pin_active;
   logic [NUM_TIME_FLAGS-1:0] time_set;
   logic                      timer_clear_edge;
   assign wr_en    = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   // ------------------------------------------------------------------
   // Input synchroniser
   // ------------------------------------------------------------------
   // The first stage feeds only the second; all logic reads pin_level.
   // Stages start at the pulled-up idle level, so no false low follows.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a    <= '1;
         pin_level <= '1;
      end else begin
         sync_a    <= pin_in;
         pin_level <= sync_a;
      end
   end
   // ------------------------------------------------------------------
   // Strap capture
   // ------------------------------------------------------------------
   // Straps are caught a few cycles after reset release, never by the
   // asynchronous reset itself.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_a     <= '0;
         strap_b     <= '0;
         strap_wait  <= '0;
         strap_taken <= 1'b0;
         led_mode    <= '0;
      end else begin
         strap_a <= led_enable_straps;
         strap_b <= strap_a;
         if (!strap_taken) begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == 2'(STRAP_WAIT - 1)) begin
               led_mode    <= strap_b;
               strap_taken <= 1'b1;
            end
         end else if (wr_en && paddr == OFS_LED_MODE) begin
            led_mode <= pwdata[NUM_LED_PINS-1:0];
         end
      end
   end
   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_value_bits        <= '0;
         pin_direction_bits    <= '0;
         pin_driver_type_bits  <= '0;
         pin_irq_polarity_bits <= '0;
         time_oe               <= '0;
         event_pol             <= '0;
         target_clear_en       <= '0;
         event_mode            <= '0;
         pin_irq_en            <= '0;
         time_en               <= '0;
      end else if (wr_en) begin
         case (paddr)
            OFS_DATA_DIR: begin
               pin_value_bits     <= pwdata[NUM_PINS-1:0];
               pin_direction_bits <= pwdata[POS_DIR +: NUM_PINS];
            end
            OFS_CONFIG: begin
               // Buffer type only matters once the pin is an output.
               pin_driver_type_bits  <= pwdata[POS_DRV +: NUM_PINS];
               pin_irq_polarity_bits <= pwdata[POS_IRQ_POL +: NUM_PINS];
               time_oe         <= pwdata[POS_TIME_OE +: NUM_TIME_PINS];
               event_pol       <= pwdata[POS_EVT_POL +: NUM_TIME_PINS];
               target_clear_en <= pwdata[POS_TCLR_EN +: NUM_TIME_PINS];
            end
            OFS_EVENT_MODE: event_mode <= pwdata[3:0];
            OFS_PIN_IRQ: pin_irq_en <= pwdata[POS_IRQ_EN +: NUM_PINS];
            OFS_TIME_IRQ: time_en <= pwdata[POS_IRQ_EN +: NUM_TIME_FLAGS];
            default: ;
         endcase
      end
   end
   // ------------------------------------------------------------------
   // Time pins: qualified capture edges and compare outputs
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_TIME_PINS; g++) begin : g_time
         localparam int P = TIME_PIN_BASE + g;
         logic [5:0]     qual_cnt;
         logic [5:0]     pulse_cnt;
         logic           toggle_q;
         logic           lvl;
         gptc_evt_mode_t mode;
         logic           active;
         assign mode   = gptc_evt_mode_t'(event_mode[2*g +: 2]);
         assign active = (pin_level[P] == pin_irq_polarity_bits[P]);
         // Fires once, after the level has held for the full count.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               qual_cnt        <= '0;
               capture_fire[g] <= 1'b0;
            end else begin
               capture_fire[g] <= 1'b0;
               if (!active || eff_dir[P]) begin
                  qual_cnt <= '0;
               end else if (qual_cnt != 6'(CAPTURE_CYCLES)) begin
                  qual_cnt <= qual_cnt + 6'h01;
                  if (qual_cnt == 6'(CAPTURE_CYCLES - 1)) begin
                     capture_fire[g] <= 1'b1;
                  end
               end
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cap_lo[g] <= RESET_WORD;
               cap_hi[g] <= RESET_WORD;
            end else if (capture_fire[g]) begin
               cap_lo[g] <= time_clock[31:0];
               cap_hi[g] <= time_clock[63:32];
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pulse_cnt <= '0;
               toggle_q  <= 1'b0;
            end else begin
               if (target_event) begin
                  pulse_cnt <= 6'(PULSE_CYCLES);
                  toggle_q  <= ~toggle_q;
               end else if (pulse_cnt != '0) begin
                  pulse_cnt <= pulse_cnt - 6'h01;
               end
            end
         end
         always_comb begin
            case (mode)
               GPTC_EVT_PULSE:  lvl = (pulse_cnt != '0);
               GPTC_EVT_TOGGLE: lvl = toggle_q;
               GPTC_EVT_FOLLOW: lvl = time_flag[POS_TIMER_FLAG];
               default:         lvl = 1'b0;
            endcase
         end
         // Polarity bit set means the output is active high.
         assign event_level[g] = event_pol[g] ? lvl : ~lvl;
      end
   endgenerate
   // ------------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------------
   always_comb begin
      eff_dir     = pin_direction_bits;
      drive_value = pin_value_bits;
      eff_dir[TIME_PIN_BASE +: NUM_TIME_PINS] =
         pin_direction_bits[TIME_PIN_BASE +: NUM_TIME_PINS] | time_oe;
      for (int i = 0; i < NUM_TIME_PINS; i++) begin
         if (time_oe[i]) begin
            drive_value[TIME_PIN_BASE + i] = event_level[i];
         end
      end
   end
   // Registered so the pads see no decode glitches.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins <= '0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (i < NUM_LED_PINS && led_mode[i]) begin
               pins.out[i] <= 1'b0;
               pins.oe[i]  <= led_on[i];
            end else if (!eff_dir[i]) begin
               pins.out[i] <= 1'b0;
               pins.oe[i]  <= 1'b0;
            end else if (pin_driver_type_bits[i]) begin
               pins.out[i] <= 1'b0;
               pins.oe[i]  <= ~drive_value[i];
            end else begin
               pins.out[i] <= drive_value[i];
               pins.oe[i]  <= 1'b1;
            end
         end
      end
   end
   // ------------------------------------------------------------------
   // Interrupt flags
   // ------------------------------------------------------------------
   // Hardware sets win over a write-one clear in the same cycle.
   assign pin_active = ~(pin_level ^ pin_irq_polarity_bits);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_irq_flag <= '0;
      end else begin
         pin_irq_flag <= (pin_irq_flag
            & ~((wr_en && paddr == OFS_PIN_IRQ) ?
                pwdata[NUM_PINS-1:0] : '0))
            | pin_active
            | {2'b00, capture_fire, 8'h00};
      end
   end
   assign timer_clear_edge = |(capture_fire & target_clear_en);
   always_comb begin
      time_set = '0;
      time_set[NUM_STAMP_SRC-1:0] = stamp_event;
      time_set[POS_CAP8_FLAG]     = capture_fire[0];
      time_set[POS_CAP9_FLAG]     = capture_fire[1];
      time_set[POS_TIMER_FLAG]    = target_event;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         time_flag <= '0;
      end else begin
         time_flag <= (time_flag
            & ~((wr_en && paddr == OFS_TIME_IRQ) ?
                pwdata[NUM_TIME_FLAGS-1:0] : '0)
            & ~{timer_clear_edge, 8'h00})
            | time_set;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_irq_summary     <= 1'b0;
         time_unit_event_bit <= 1'b0;
      end else begin
         pin_irq_summary     <= |(pin_irq_flag & pin_irq_en);
         time_unit_event_bit <= |(time_flag & time_en);
      end
   end
   // ------------------------------------------------------------------
   // APB read path
   // ------------------------------------------------------------------
   always_comb begin
      next_prdata = '0;
      addr_ok     = 1'b1;
      case (paddr)
         OFS_DATA_DIR: begin
            // Inputs show the pin; outputs show the stored bit.
            next_prdata[NUM_PINS-1:0] = (pin_value_bits & eff_dir)
                                      | (pin_level & ~eff_dir);
            next_prdata[POS_DIR +: NUM_PINS] = pin_direction_bits;
         end
         OFS_CONFIG: begin
            next_prdata[POS_DRV +: NUM_PINS]     = pin_driver_type_bits;
            next_prdata[POS_IRQ_POL +: NUM_PINS] = pin_irq_polarity_bits;
            next_prdata[POS_TIME_OE +: NUM_TIME_PINS] = time_oe;
            next_prdata[POS_EVT_POL +: NUM_TIME_PINS] = event_pol;
            next_prdata[POS_TCLR_EN +: NUM_TIME_PINS] = target_clear_en;
         end
         OFS_PIN_IRQ: begin
            next_prdata[NUM_PINS-1:0]          = pin_irq_flag;
            next_prdata[POS_IRQ_EN +: NUM_PINS] = pin_irq_en;
         end
         OFS_TIME_IRQ: begin
            next_prdata[NUM_TIME_FLAGS-1:0]          = time_flag;
            next_prdata[POS_IRQ_EN +: NUM_TIME_FLAGS] = time_en;
         end
         OFS_EVENT_MODE: next_prdata[3:0] = event_mode;
         OFS_SYS_STATUS: begin
            next_prdata[POS_SYS_PIN_IRQ]  = pin_irq_summary;
            next_prdata[POS_SYS_TIME_EVT] = time_unit_event_bit;
         end
         OFS_CAP8_LO: next_prdata = cap_lo[0];
         OFS_CAP8_HI: next_prdata = cap_hi[0];
         OFS_CAP9_LO: next_prdata = cap_lo[1];
         OFS_CAP9_HI: next_prdata = cap_hi[1];
         OFS_LED_MODE: next_prdata[NUM_LED_PINS-1:0] = led_mode;
         default: addr_ok = 1'b0;
      endcase
   end

   // Data is latched in the setup cycle so the access phase needs no wait.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (rd_setup) begin
         prdata  <= pwrite ? '0 : next_prdata;
         pslverr <= ~addr_ok;
      end
   end

   assign pready = 1'b1;

endmodule

/* sim/gptc_pin_model.sv */
// Board-side model of the twelve pins: pull-ups and external drivers.
module gptc_pin_model
   import gptc_pkg::*;
(
   input  wire gptc_pins_t          pins,
   input  wire logic [NUM_PINS-1:0] ext_en,
   input  wire logic [NUM_PINS-1:0] ext_val,
   output logic [NUM_PINS-1:0]      pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released pin floats up, so open-drain high reads as one.
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pin_in[i] = pins.oe[i] ? pins.out[i] :
            (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule

/* sim/gptc_port_bench.sv */
// Self-checking bench for the time-capture pin port.
module gptc_port_bench
   import gptc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        target_event, pin_sum, time_evt, err, v;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] pin_in, ext_en, ext_val;
   logic [63:0] tclk, t0, cap;
   gptc_pins_t  pins;
   int          err_count, n_checks, cycles, n;
   gptc_port #(.PULSE_CYCLES(PULSE_CYC), .CAPTURE_CYCLES(CAPTURE_CYC)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pins(pins),
      .time_clock(tclk), .target_event(target_event),
      .stamp_event(6'h00), .led_enable_straps(8'h00), .led_on(8'hFF),
      .pin_irq_summary(pin_sum), .time_unit_event_bit(time_evt));
   gptc_pin_model board (.pins(pins), .ext_en(ext_en), .ext_val(ext_val),
      .pin_in(pin_in));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      tclk <= tclk + 64'h1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         conclude();
      end
   end
   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task automatic fire();
      @(posedge pclk);
      target_event <= 1'b1;
      @(posedge pclk);
      target_event <= 1'b0;
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      apb(1'b0, OFS_DATA_DIR, 32'h0);
      check(rd, 32'h0000_0FFF);
      apb(1'b0, OFS_CONFIG, 32'h0);
      check(rd, RESET_WORD);
      apb(1'b0, OFS_PIN_IRQ, 32'h0);
      check(rd, RESET_WORD);
      apb(1'b0, 8'h2C, 32'h0);
      check({err, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, OFS_LED_MODE, 32'h1);
      idle(2);
      check(32'(pins.oe[0]), 32'h1);
      apb(1'b1, OFS_LED_MODE, 32'h0);
   endtask
   task automatic t_drive();
      apb(1'b1, OFS_DATA_DIR, 32'h0C00_0400);
      apb(1'b1, OFS_CONFIG, 32'h0000_0800);
      idle(2);
      check(32'(pins.oe[11:10]), 32'h3);
      check(32'(pins.out[11:10]), 32'h1);
      apb(1'b1, OFS_DATA_DIR, 32'h0C00_0800);
      ext_en[3] <= 1'b1;
      idle(4);
      check(32'(pins.oe[11:10]), 32'h1);
      apb(1'b0, OFS_DATA_DIR, 32'h0);
      check(rd, 32'h0C00_0BF7);
      apb(1'b1, OFS_DATA_DIR, 32'h0);
   endtask
   task automatic t_pin_irq();
      // Released pins must pass the synchroniser before flags are cleared.
      idle(4);
      apb(1'b1, OFS_PIN_IRQ, 32'h0008_0FFF);
      idle(2);
      apb(1'b0, OFS_PIN_IRQ, 32'h0);
      check(rd, 32'h0008_0008);
      check(32'(pin_sum), 32'h1);
      apb(1'b0, OFS_SYS_STATUS, 32'h0);
      check(rd, 32'h0000_1000);
      apb(1'b1, OFS_CONFIG, 32'h0000_8000);
      apb(1'b1, OFS_PIN_IRQ, 32'h0008_0008);
      idle(2);
      check(32'(pin_sum), 32'h0);
      ext_en[3] <= 1'b0;
      idle(4);
      apb(1'b0, OFS_PIN_IRQ, 32'h0);
      check(rd, 32'h0008_0008);
      apb(1'b1, OFS_CONFIG, 32'h0);
      apb(1'b1, OFS_PIN_IRQ, 32'h0000_0FFF);
   endtask
   task automatic t_capture();
      apb(1'b1, OFS_CONFIG, 32'h2000_0000);
      apb(1'b1, OFS_TIME_IRQ, 32'h0180_0000);
      fire();
      idle(2);
      apb(1'b0, OFS_TIME_IRQ, 32'h0);
      check(rd, 32'h0180_0100);
      check(32'(time_evt), 32'h1);
      // Exactly 40 ns low is too short to count.
      ext_en[9] <= 1'b1;
      idle(10);
      ext_en[9] <= 1'b0;
      idle(6);
      apb(1'b0, OFS_TIME_IRQ, 32'h0);
      check(rd, 32'h0180_0100);
      t0 = tclk;
      ext_en[9] <= 1'b1;
      idle(20);
      ext_en[9] <= 1'b0;
      idle(4);
      apb(1'b0, OFS_TIME_IRQ, 32'h0);
      check(rd, 32'h0180_0080);
      apb(1'b0, OFS_PIN_IRQ, 32'h0);
      check(rd, 32'h0000_0200);
      apb(1'b0, OFS_CAP9_LO, 32'h0);
      cap[31:0] = rd;
      apb(1'b0, OFS_CAP9_HI, 32'h0);
      cap[63:32] = rd;
      check(32'(cap >= t0 && cap <= t0 + 64'h14), 32'h1);
      apb(1'b1, OFS_TIME_IRQ, 32'h0000_01FF);
      apb(1'b1, OFS_CONFIG, 32'h0);
      idle(2);
      check(32'(time_evt), 32'h0);
   endtask
   task automatic t_event_out();
      apb(1'b1, OFS_CONFIG, 32'h0500_0000);
      apb(1'b1, OFS_EVENT_MODE, 32'h0);
      idle(2);
      check(32'(pins.oe[8]), 32'h1);
      fire();
      n = 0;
      repeat (40) begin
         @(posedge pclk);
         if (pins.out[8] === 1'b1) n++;
      end
      check(32'(n), 32'(PULSE_CYC));
      apb(1'b1, OFS_EVENT_MODE, 32'h1);
      idle(2);
      v = pins.out[8];
      fire();
      idle(3);
      check(32'(pins.out[8]), 32'(!v));
      apb(1'b1, OFS_TIME_IRQ, 32'h0000_0100);
      apb(1'b1, OFS_EVENT_MODE, 32'h2);
      idle(2);
      check(32'(pins.out[8]), 32'h0);
      fire();
      idle(3);
      check(32'(pins.out[8]), 32'h1);
      apb(1'b1, OFS_TIME_IRQ, 32'h0000_0100);
      idle(2);
      check(32'(pins.out[8]), 32'h0);
   endtask
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, target_event} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext_en = 12'h000;
      ext_val = 12'h000;
      tclk = 64'h0000_0001_FFFF_FFF0;
      {err_count, n_checks, cycles} = {32'h0, 32'h0, 32'h0};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      idle(5);
      t_reset();
      t_drive();
      t_pin_irq();
      t_capture();
      t_event_out();
      conclude();
   end
endmodule

bind gptc_port gptc_port_chk #(.PULSE_CYCLES(PULSE_CYCLES),
   .CAPTURE_CYCLES(CAPTURE_CYCLES)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pins(pins), .pin_irq_summary(pin_irq_summary),
   .time_unit_event_bit(time_unit_event_bit));

/* sim/gptc_port_chk.sv */
// Concurrent checks on the ports of the time-capture pin port.
module gptc_port_chk
   import gptc_pkg::*;
#(
   parameter int PULSE_CYCLES   = PULSE_CYC,
   parameter int CAPTURE_CYCLES = CAPTURE_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire gptc_pins_t  pins,
   input  wire logic        pin_irq_summary,
   input  wire logic        time_unit_event_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       wr;
   logic       rd_setup;
   logic [1:0] dir_s;
   logic [1:0] val_s;
   logic [1:0] drv_s;
   logic [1:0] quiet;
   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // -----------------------------------------------------------------
   // Shadow of pins 11 and 10, which have no time or lamp function.
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_s <= 2'h0;
         val_s <= 2'h0;
         drv_s <= 2'h0;
      end else if (wr && paddr == OFS_DATA_DIR) begin
         val_s <= pwdata[11:10];
         dir_s <= pwdata[27:26];
      end else if (wr && paddr == OFS_CONFIG) begin
         drv_s <= pwdata[11:10];
      end
   end
   // The drivers settle in two cycles, so the check waits for quiet.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet <= 2'h3;
      end else begin
         quiet <= wr ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
      end
   end
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   a_ready_high: assert property (pready)
      else $error("ready low");
   a_reset_inputs: assert property ($rose(presetn) |->
      (pins.oe == 12'h000 && !pin_irq_summary)[*2])
      else $error("pins driven after reset");
   a_unmapped_err: assert property (psel && !penable &&
      paddr > OFS_LED_MODE |=> pslverr)
      else $error("no error on unmapped address");
   a_unmapped_zero: assert property (rd_setup &&
      paddr > OFS_LED_MODE |=> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_sys_pin_bit: assert property (rd_setup && paddr == OFS_SYS_STATUS
      ##1 $stable(pin_irq_summary) |->
      prdata[POS_SYS_PIN_IRQ] == pin_irq_summary)
      else $error("pin summary bit wrong");
   a_sys_time_bit: assert property (rd_setup && paddr == OFS_SYS_STATUS
      ##1 $stable(time_unit_event_bit) |->
      prdata[POS_SYS_TIME_EVT] == time_unit_event_bit)
      else $error("time event bit wrong");
   a_drive_follow: assert property (quiet >= 2'h2 |->
      pins.oe[11:10] == (dir_s & ~(drv_s & val_s)) &&
      (pins.out[11:10] & dir_s) == (val_s & ~drv_s & dir_s))
      else $error("pin driver wrong");
   a_oe_cause: assert property (!$stable(pins.oe[11:10]) |->
      $past(wr) || $past(wr, 2))
      else $error("enable moved without a write");
   c_event_mode: cover property (wr && paddr == OFS_EVENT_MODE);
   c_time_evt: cover property ($rose(time_unit_event_bit));
   c_pin_irq: cover property ($rose(pin_irq_summary));
endmodule
